// ---- core/ingress_meter_table_access.sv ----
// Purpose: Indirect ingress meter table, command engine, filtered count
// Assumes: One clock; event inputs come from logic on the same clock
// Notes: Read data appear only in the cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
module ingress_meter_table_access
	import meter_table_pkg::*;
#(
	parameter int ENTRIES = RATE_ENTRIES
)
(
	input wire logic i_mclk, // 250 MHz clock
	input wire logic i_reset, // Async reset, high
	input wire logic [15:0] i_addr, // Byte address
	input wire logic [31:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [31:0] o_rdata, // Read data, cycle after strobe
	output logic o_irq, // Level interrupt
	input wire logic i_filtered, // Host port packet filtered pulse
	input wire logic i_rate_drop, // Filter was a rate limit drop
	input wire lookup_key_t i_lookup, // Port and priority of packet
	input wire logic i_lookup_valid, // Lookup request pulse
	output logic [15:0] o_rate_entry, // Selected rate entry
	output logic [20:0] o_byte_time_ns, // Allowed ns per byte
	output logic [15:0] o_cbs, // Committed burst size
	output logic [15:0] o_ebs, // Excess burst size
	input wire logic [15:0] i_cbucket, // Committed bucket level
	input wire logic [15:0] i_ebucket, // Excess bucket level
	output logic [15:0] o_ccap, // Committed refill cap
	output logic [15:0] o_ecap, // Excess refill cap
	input wire logic i_color_req, // Coloring request pulse
	input wire logic i_over_cir, // Packet exceeds committed rate
	input wire logic i_over_eir, // Packet exceeds excess rate
	input wire logic [15:0] i_pkt_len, // Packet length in bytes
	output logic o_drop, // Certain drop
	output logic o_random_drop, // Random early discard candidate
	output logic o_meter_enable // Metering enabled
);

	// ======================================================
	// Elaboration checks
	if (ENTRIES < 1 || ENTRIES > 32)
	begin : g_bad_entries
		$error("ENTRIES must lie in 1..32");
	end

	// ======================================================
	// Storage
	logic [15:0] rate_table_reg [ENTRIES];
	logic [15:0] cbs_reg;
	logic [15:0] ebs_reg;
	logic [2:0] rate_meter_config_reg;
	rate_table_command_t cmd_reg;
	logic [15:0] rate_table_write_data_reg;
	logic [15:0] rate_table_read_data_reg;
	logic [31:0] host_port_filtered_count_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	cmd_state_t state_reg;
	logic pending_reg;

	// ======================================================
	// Decode
	logic [13:0] idx;
	logic aligned;
	logic wr_cmd;
	logic rd_count;
	logic count_event;
	logic count_sat_hit;
	logic done_event;
	logic entry_ok;
	assign idx = i_addr[15:2];
	assign aligned = (i_addr[1:0] == 2'h0);
	assign wr_cmd = i_wr && aligned && (idx == IDX_RATE_CMD);
	assign rd_count = i_rd && aligned && (idx == IDX_FILT_COUNT);
	// Rate limit drops are counted elsewhere
	assign count_event = i_filtered && !i_rate_drop;
	assign entry_ok = (32'(cmd_reg.entry_index) < ENTRIES);
	assign done_event = (state_reg == ST_EXEC);

	// ======================================================
	// Software visible control registers
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			rate_meter_config_reg <= 3'h0;
			cmd_reg <= '0;
			rate_table_write_data_reg <= DATA_RESET;
			irq_mask_reg <= 2'h0;
		end
		else if (i_wr && aligned)
		begin
			case (idx)
				IDX_RATE_CFG: rate_meter_config_reg <= i_wdata[2:0];
				IDX_RATE_CMD: cmd_reg <= i_wdata[7:0];
				IDX_WR_DATA: rate_table_write_data_reg <= i_wdata[15:0];
				IDX_IRQ_MASK: irq_mask_reg <= i_wdata[1:0];
				default: ;
			endcase
		end
	end

	// ======================================================
	// Command engine
	// A command written while one runs is taken at face value:
	// the register updates, and the engine restarts with it.
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			state_reg <= ST_IDLE;
			pending_reg <= 1'b0;
		end
		else if (wr_cmd)
		begin
			state_reg <= ST_EXEC;
			pending_reg <= 1'b1;
		end
		else
		begin
			case (state_reg)
				ST_IDLE: pending_reg <= 1'b0;
				ST_EXEC:
				begin
					state_reg <= ST_DONE;
					pending_reg <= 1'b1;
				end
				ST_DONE:
				begin
					state_reg <= ST_IDLE;
					pending_reg <= 1'b0;
				end
				default:
				begin
					state_reg <= ST_IDLE;
					pending_reg <= 1'b0;
				end
			endcase
		end
	end

	// ======================================================
	// Table access, only through the command engine
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			for (int i = 0; i < ENTRIES; i++)
			begin
				rate_table_reg[i] <= RATE_RESET;
			end
			cbs_reg <= BURST_RESET;
			ebs_reg <= BURST_RESET;
		end
		else if (done_event && !cmd_reg.access_direction)
		begin
			case (cmd_reg.entry_type)
				TYPE_RATE:
				begin
					if (entry_ok)
					begin
						rate_table_reg[cmd_reg.entry_index] <=
							rate_table_write_data_reg;
					end
				end
				TYPE_CBS: cbs_reg <= rate_table_write_data_reg;
				TYPE_EBS: ebs_reg <= rate_table_write_data_reg;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			rate_table_read_data_reg <= DATA_RESET;
		end
		else if (done_event && cmd_reg.access_direction)
		begin
			case (cmd_reg.entry_type)
				TYPE_RATE: rate_table_read_data_reg <= entry_ok ?
					rate_table_reg[cmd_reg.entry_index] : DATA_RESET;
				TYPE_CBS: rate_table_read_data_reg <= cbs_reg;
				TYPE_EBS: rate_table_read_data_reg <= ebs_reg;
				default: rate_table_read_data_reg <= DATA_RESET;
			endcase
		end
	end

	// ======================================================
	// Host port filtered count
	// A packet in the clearing read's cycle is kept as a count of one
	// A clearing read in the same cycle keeps the count far from the top
	assign count_sat_hit = count_event && !rd_count &&
		(host_port_filtered_count_reg == COUNT_MAX - 32'h1);
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			host_port_filtered_count_reg <= COUNT_RESET;
		end
		else if (rd_count)
		begin
			host_port_filtered_count_reg <= count_event ?
				32'h1 : COUNT_RESET;
		end
		else if (count_event &&
			host_port_filtered_count_reg != COUNT_MAX)
		begin
			host_port_filtered_count_reg <=
				host_port_filtered_count_reg + 32'h1;
		end
	end

	// ======================================================
	// Interrupt status, write one to clear, set wins
	logic [1:0] irq_set;
	logic [1:0] irq_clr;
	assign irq_set = {count_sat_hit, done_event};
	assign irq_clr = (i_wr && aligned && idx == IDX_IRQ_STATUS) ?
		i_wdata[1:0] : 2'h0;
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			irq_status_reg <= 2'h0;
			o_irq <= 1'b0;
		end
		else
		begin
			irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
			o_irq <= |(((irq_status_reg & ~irq_clr) | irq_set) &
				irq_mask_reg);
		end
	end

	// ======================================================
	// Register read port
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_rdata <= 32'h0;
		end
		else if (i_rd && aligned)
		begin
			case (idx)
				IDX_RATE_CFG: o_rdata <= {29'h0, rate_meter_config_reg};
				IDX_RATE_CMD: o_rdata <= {24'h0, cmd_reg};
				IDX_CMD_STATUS: o_rdata <= {31'h0, pending_reg};
				IDX_WR_DATA: o_rdata <= {16'h0, rate_table_write_data_reg};
				IDX_RD_DATA: o_rdata <= {16'h0, rate_table_read_data_reg};
				IDX_FILT_COUNT: o_rdata <= host_port_filtered_count_reg;
				IDX_IRQ_STATUS: o_rdata <= {30'h0, irq_status_reg};
				IDX_IRQ_MASK: o_rdata <= {30'h0, irq_mask_reg};
				default: o_rdata <= 32'h0;
			endcase
		end
		else
		begin
			o_rdata <= 32'h0;
		end
	end

	// ======================================================
	// Rate entry lookup for the meter
	logic [4:0] lookup_index;
	rate_mode_t mode;
	assign mode = rate_mode_t'(rate_meter_config_reg[2:1]);
	always_comb
	begin
		case (mode)
			MODE_PORT_PRIO: lookup_index = {i_lookup.port, i_lookup.prio};
			MODE_PORT_ONLY: lookup_index = {3'h0, i_lookup.port};
			MODE_PRIO_ONLY: lookup_index = {2'h0, i_lookup.prio};
			default: lookup_index = 5'h0;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_rate_entry <= RATE_RESET;
			o_byte_time_ns <= 21'h0;
		end
		else if (i_lookup_valid)
		begin
			// Out of range indexes read the reset rate
			if (32'(lookup_index) < ENTRIES)
			begin
				o_rate_entry <= rate_table_reg[lookup_index];
				o_byte_time_ns <= 21'((21'(rate_table_reg[lookup_index])
					+ 21'h1) * 21'(BYTE_TIME_UNIT_NS));
			end
			else
			begin
				o_rate_entry <= RATE_RESET;
				o_byte_time_ns <= 21'((21'(RATE_RESET) + 21'h1)
					* 21'(BYTE_TIME_UNIT_NS));
			end
		end
	end

	// ======================================================
	// Burst limits, bucket caps and coloring
	// A bucket above a lowered burst keeps its level as cap, so it
	// only shrinks to the new limit by normal depletion.
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_cbs <= BURST_RESET;
			o_ebs <= BURST_RESET;
			o_ccap <= BURST_RESET;
			o_ecap <= BURST_RESET;
			o_meter_enable <= 1'b0;
		end
		else
		begin
			o_cbs <= cbs_reg;
			o_ebs <= ebs_reg;
			o_ccap <= (i_cbucket > cbs_reg) ? i_cbucket : cbs_reg;
			o_ecap <= (i_ebucket > ebs_reg) ? i_ebucket : ebs_reg;
			o_meter_enable <= rate_meter_config_reg[CFG_ENABLE_BIT];
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_drop <= 1'b0;
			o_random_drop <= 1'b0;
		end
		else if (i_color_req && rate_meter_config_reg[CFG_ENABLE_BIT])
		begin
			o_drop <= i_over_eir && (i_pkt_len > i_ebucket);
			o_random_drop <= !(i_over_eir && (i_pkt_len > i_ebucket))
				&& i_over_cir && (i_pkt_len > i_cbucket);
		end
		else
		begin
			o_drop <= 1'b0;
			o_random_drop <= 1'b0;
		end
	end

endmodule // ingress_meter_table_access
`default_nettype wire

// ---- core/meter_table_pkg.sv ----
// Purpose: Constants and types for the ingress meter table access block
// Assumes: 32-bit register port, byte address is four times the index
// Notes: Offsets below are register indexes, not byte addresses
// Operation
// - 24 rate entries plus two bursts
// - Entries 16 bits, indirect access only
// - Excess burst resets 0600h, excess drop
// - Committed burst resets 0600h, random drop
// - Buckets start full; lower cap after depletion
// - Byte time is entry plus one times 20ns
// - Pending bit set while command runs
// - Write data register, bits 15:0, RW
// - Read data register shows last fetch
// - Count host port filtered, not rate drops
// - 32-bit count resets, clears on read
// - Count saturates at FFFF_FFFFh
// - Command write launches; bit 7 reads
// - Type 6:5 selects entry kind
// - Port and priority groups of eight
package meter_table_pkg;

	// ======================================================
	// Register indexes (byte address is index times four)
	localparam logic [13:0] IDX_RATE_CFG = 14'h184a;
	localparam logic [13:0] IDX_RATE_CMD = 14'h184b;
	localparam logic [13:0] IDX_CMD_STATUS = 14'h184c;
	localparam logic [13:0] IDX_WR_DATA = 14'h184d;
	localparam logic [13:0] IDX_RD_DATA = 14'h184e;
	localparam logic [13:0] IDX_FILT_COUNT = 14'h1850;
	localparam logic [13:0] IDX_IRQ_STATUS = 14'h1860;
	localparam logic [13:0] IDX_IRQ_MASK = 14'h1861;

	// ======================================================
	// Field positions
	localparam int CMD_DIR_BIT = 7;
	localparam int CMD_TYPE_LSB = 5;
	localparam int CMD_INDEX_LSB = 0;
	localparam int CFG_ENABLE_BIT = 0;
	localparam int CFG_MODE_LSB = 1;
	localparam int STS_PENDING_BIT = 0;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_SAT_BIT = 1;

	// ======================================================
	// Reset values and limits
	localparam logic [15:0] BURST_RESET = 16'h0600;
	localparam logic [15:0] RATE_RESET = 16'h0014;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [31:0] COUNT_RESET = 32'h00000000;
	localparam logic [31:0] COUNT_MAX = 32'hffffffff;
	localparam int RATE_ENTRIES = 24;
	localparam int PRIO_PER_PORT = 8;

	// ======================================================
	// Timing: byte time unit, and its length in cycles
	localparam int BYTE_TIME_UNIT_NS = 20;
	localparam int CLK_PERIOD_NS = 4;
	localparam int BYTE_TIME_UNIT_CYC = BYTE_TIME_UNIT_NS / CLK_PERIOD_NS;

	// ======================================================
	// Types
	typedef enum logic [1:0] {
		TYPE_RESERVED = 2'h0,
		TYPE_RATE = 2'h1,
		TYPE_CBS = 2'h2,
		TYPE_EBS = 2'h3
	} entry_type_t;

	typedef enum logic [1:0] {
		MODE_PORT_PRIO = 2'h0,
		MODE_PORT_ONLY = 2'h1,
		MODE_PRIO_ONLY = 2'h2,
		MODE_RESERVED = 2'h3
	} rate_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_DONE = 2'h3
	} cmd_state_t;

	typedef struct packed {
		logic access_direction;
		entry_type_t entry_type;
		logic [4:0] entry_index;
	} rate_table_command_t;

	typedef struct packed {
		logic [1:0] port;
		logic [2:0] prio;
	} lookup_key_t;

endpackage

// ---- verif/meter_table_asserts.sv ----
// Purpose: Port assertions for the meter table block
// Assumes: One clock, async reset high
// Notes: Bound to every instance
`timescale 1ns/10ps
`default_nettype none
module meter_table_asserts
	import meter_table_pkg::*;
(
	input wire logic i_mclk, // Clock
	input wire logic i_reset, // Reset
	input wire logic [15:0] i_addr, // Address
	input wire logic i_wr, // Write
	input wire logic i_rd, // Read
	input wire logic [31:0] o_rdata, // Read data
	input wire logic i_filtered, // Filter event
	input wire logic i_lookup_valid, // Lookup
	input wire logic [15:0] o_rate_entry, // Entry
	input wire logic [20:0] o_byte_time_ns, // Byte time
	input wire logic [15:0] o_cbs, // Burst
	input wire logic [15:0] i_cbucket, // C level
	input wire logic [15:0] i_ebucket, // E level
	input wire logic [15:0] o_ccap, // C cap
	input wire logic i_color_req, // Color
	input wire logic i_over_cir, // Over C
	input wire logic i_over_eir, // Over E
	input wire logic [15:0] i_pkt_len, // Length
	input wire logic o_drop, // Drop
	input wire logic o_random_drop, // Random
	input wire logic o_meter_enable // Enable
);
	// ======================================================
	// Properties
	localparam logic [15:0] A_CMD = {IDX_RATE_CMD, 2'h0};
	localparam logic [15:0] A_STS = {IDX_CMD_STATUS, 2'h0};
	localparam logic [15:0] A_RDD = {IDX_RD_DATA, 2'h0};
	localparam logic [15:0] A_CNT = {IDX_FILT_COUNT, 2'h0};
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	property p_rdata_idle;
		!i_rd |=> o_rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero when idle");
	property p_rd_upper;
		i_rd && i_addr == A_RDD |=> o_rdata[31:16] == 16'h0;
	endproperty
	a_rd_upper: assert property (p_rd_upper)
		else $error("read data upper bits set");
	property p_pend_rise;
		i_wr && i_addr == A_CMD ##1 i_rd && i_addr == A_STS |=> o_rdata[0];
	endproperty
	a_pend_rise: assert property (p_pend_rise)
		else $error("pending not set after command");
	property p_byte_time;
		i_lookup_valid |=> o_byte_time_ns ==
			(21'(o_rate_entry) + 21'h1) * 21'(BYTE_TIME_UNIT_NS);
	endproperty
	a_byte_time: assert property (p_byte_time)
		else $error("byte time wrong");
	// Enable output lags the config bit by one cycle, like the drops
	property p_drop;
		i_color_req && i_over_eir && i_pkt_len > i_ebucket ##1 o_meter_enable
			|-> o_drop && !o_random_drop;
	endproperty
	a_drop: assert property (p_drop)
		else $error("drop missing");
	property p_rdrop;
		i_color_req && !i_over_eir && i_over_cir &&
			i_pkt_len > i_cbucket ##1 o_meter_enable
			|-> o_random_drop && !o_drop;
	endproperty
	a_rdrop: assert property (p_rdrop)
		else $error("random drop missing");
	property p_quiet;
		!i_color_req |=> !o_drop && !o_random_drop;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("drop without request");
	property p_ccap;
		1 |=> o_ccap == ($past(i_cbucket) > o_cbs ? $past(i_cbucket) : o_cbs);
	endproperty
	a_ccap: assert property (p_ccap)
		else $error("committed cap wrong");
	property p_cnt_clear;
		(i_rd && i_addr == A_CNT && !i_filtered) ##1 (i_rd && i_addr == A_CNT)
			|=> o_rdata == 32'h0;
	endproperty
	a_cnt_clear: assert property (p_cnt_clear)
		else $error("count not cleared by read");
	c_cmd: cover property (i_wr && i_addr == A_CMD);
	c_drop: cover property (o_drop);
	c_rdrop: cover property (o_random_drop);
endmodule // meter_table_asserts
bind ingress_meter_table_access meter_table_asserts u_asserts (.i_mclk,
	.i_reset, .i_addr, .i_wr, .i_rd, .o_rdata, .i_filtered, .i_lookup_valid,
	.o_rate_entry, .o_byte_time_ns, .o_cbs, .i_cbucket, .i_ebucket, .o_ccap,
	.i_color_req, .i_over_cir, .i_over_eir, .i_pkt_len, .o_drop,
	.o_random_drop, .o_meter_enable);
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: Register level tests of the meter table block
// Assumes: Tasks start just after a clock edge
// Notes: Inputs are set 1 ns after an edge; strobes drop at the edge
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import meter_table_pkg::*;
	logic i_mclk, i_reset, i_wr, i_rd, i_filtered, i_rate_drop;
	logic i_lookup_valid, i_color_req, i_over_cir, i_over_eir;
	logic [15:0] i_addr, i_cbucket, i_ebucket, i_pkt_len;
	logic [31:0] i_wdata, rd_val, o_rdata;
	lookup_key_t i_lookup;
	logic o_irq, o_drop, o_random_drop, o_meter_enable;
	logic [15:0] o_rate_entry, o_cbs, o_ebs, o_ccap, o_ecap;
	logic [20:0] o_byte_time_ns;
	int errors = 0;
	int checks = 0;
	ingress_meter_table_access dut (.i_mclk, .i_reset, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .o_irq, .i_filtered, .i_rate_drop, .i_lookup,
		.i_lookup_valid, .o_rate_entry, .o_byte_time_ns, .o_cbs, .o_ebs,
		.i_cbucket, .i_ebucket, .o_ccap, .o_ecap, .i_color_req, .i_over_cir,
		.i_over_eir, .i_pkt_len, .o_drop, .o_random_drop, .o_meter_enable);
	// ======================================================
	// Tasks
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [13:0] idx, input logic [31:0] d);
		i_addr <= {idx, 2'h0};
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [13:0] idx);
		i_addr <= {idx, 2'h0};
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		rd_val = o_rdata;
	endtask
	// Pending must show for exactly two status reads
	task automatic cmd(input logic dir, input entry_type_t t,
		input logic [4:0] n);
		rate_table_command_t c;
		c = '{dir, t, n};
		wr(IDX_RATE_CMD, {24'h0, c});
		rd(IDX_CMD_STATUS);
		chk("pending c1", 32'h1, rd_val);
		rd(IDX_CMD_STATUS);
		chk("pending c2", 32'h1, rd_val);
		rd(IDX_CMD_STATUS);
		chk("pending c3", 32'h0, rd_val);
	endtask
	task automatic look(input logic [1:0] p, input logic [2:0] q);
		i_lookup <= '{p, q};
		i_lookup_valid <= 1'b1;
		@(posedge i_mclk);
		i_lookup_valid <= 1'b0;
		#1;
	endtask
	task automatic color(input logic c, input logic e,
		input logic [15:0] n);
		i_over_cir <= c;
		i_over_eir <= e;
		i_pkt_len <= n;
		i_color_req <= 1'b1;
		@(posedge i_mclk);
		i_color_req <= 1'b0;
		#1;
	endtask
	task automatic filt(input logic r);
		i_filtered <= 1'b1;
		i_rate_drop <= r;
		@(posedge i_mclk);
		i_filtered <= 1'b0;
		#1;
	endtask
	// ======================================================
	// Clock, watchdog, tests
	initial
	begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	initial
	begin
		#20000;
		errors++;
		end_of_test();
	end
	initial
	begin
		{i_wr, i_rd, i_filtered, i_rate_drop, i_lookup_valid} = '0;
		{i_color_req, i_over_cir, i_over_eir, i_addr, i_wdata} = '0;
		i_lookup = '0;
		i_pkt_len = 16'h0;
		i_cbucket = 16'h0100;
		i_ebucket = 16'h0200;
		i_reset = 1'b1;
		repeat (5) @(posedge i_mclk);
		i_reset <= 1'b0;
		#1;
		rd(IDX_CMD_STATUS);
		chk("status", 32'h0, rd_val);
		rd(IDX_WR_DATA);
		chk("wr data", 32'h0, rd_val);
		rd(IDX_RD_DATA);
		chk("rd data", 32'h0, rd_val);
		rd(IDX_FILT_COUNT);
		chk("count", COUNT_RESET, rd_val);
		rd(14'h1fff);
		chk("unmapped", 32'h0, rd_val);
		chk("ccap", 32'(BURST_RESET), 32'(o_ccap));
		chk("ecap", 32'(BURST_RESET), 32'(o_ecap));
		$display("test reset done");
		cmd(1'b1, TYPE_RATE, 5'd23);
		rd(IDX_RD_DATA);
		chk("rate 23", 32'(RATE_RESET), rd_val);
		cmd(1'b1, TYPE_CBS, 5'd0);
		rd(IDX_RD_DATA);
		chk("cbs", 32'(BURST_RESET), rd_val);
		cmd(1'b1, TYPE_EBS, 5'd0);
		rd(IDX_RD_DATA);
		chk("ebs", 32'(BURST_RESET), rd_val);
		wr(IDX_WR_DATA, 32'h0000abcd);
		cmd(1'b0, TYPE_RATE, 5'd9);
		cmd(1'b1, TYPE_RATE, 5'd9);
		rd(IDX_RD_DATA);
		chk("rate 9", 32'h0000abcd, rd_val);
		cmd(1'b1, TYPE_RATE, 5'd8);
		rd(IDX_RD_DATA);
		chk("rate 8", 32'(RATE_RESET), rd_val);
		cmd(1'b1, TYPE_RESERVED, 5'd9);
		rd(IDX_RD_DATA);
		chk("reserved", 32'h0, rd_val);
		wr(IDX_WR_DATA, 32'h00000400);
		cmd(1'b0, TYPE_CBS, 5'd0);
		chk("o_cbs", 32'h400, 32'(o_cbs));
		chk("ccap low", 32'h400, 32'(o_ccap));
		// Bucket above the lowered burst keeps its level as cap
		i_cbucket <= 16'h0500;
		@(posedge i_mclk);
		#1;
		chk("ccap kept", 32'h500, 32'(o_ccap));
		i_cbucket <= 16'h0100;
		chk("o_ebs", 32'(BURST_RESET), 32'(o_ebs));
		look(2'h1, 3'h1);
		chk("entry", 32'habcd, 32'(o_rate_entry));
		chk("ns", 32'habce * 32'h14, 32'(o_byte_time_ns));
		look(2'h1, 3'h0);
		chk("ns p1", 32'h15 * 32'h14, 32'(o_byte_time_ns));
		$display("test table done");
		wr(IDX_RATE_CFG, 32'h1);
		color(1'b1, 1'b1, 16'h0300);
		chk("drop", 32'h2, {o_drop, o_random_drop});
		chk("enable", 32'h1, 32'(o_meter_enable));
		color(1'b1, 1'b0, 16'h0101);
		chk("random", 32'h1, {o_drop, o_random_drop});
		color(1'b1, 1'b1, 16'h0100);
		chk("edge", 32'h0, {o_drop, o_random_drop});
		$display("test color done");
		wr(IDX_WR_DATA, 32'h00000022);
		cmd(1'b0, TYPE_RATE, 5'd1);
		wr(IDX_RATE_CFG, 32'h3);
		look(2'h1, 3'h6);
		chk("port mode", 32'h22, 32'(o_rate_entry));
		wr(IDX_RATE_CFG, 32'h5);
		look(2'h3, 3'h1);
		chk("prio mode", 32'h22, 32'(o_rate_entry));
		$display("test mode done");
		filt(1'b0);
		filt(1'b1);
		filt(1'b0);
		rd(IDX_FILT_COUNT);
		chk("count 2", 32'h2, rd_val);
		rd(IDX_FILT_COUNT);
		chk("cleared", 32'h0, rd_val);
		$display("test count done");
		chk("irq masked", 32'h0, 32'(o_irq));
		wr(IDX_IRQ_MASK, 32'h1);
		rd(IDX_IRQ_STATUS);
		chk("irq", 32'h1, 32'(o_irq));
		wr(IDX_IRQ_STATUS, 32'h1);
		rd(IDX_IRQ_STATUS);
		chk("irq status", 32'h0, rd_val);
		chk("irq low", 32'h0, 32'(o_irq));
		$display("test irq done");
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
